//--- verilog/thbs_map.vh
// constants for the per-channel transmit buffer switch sequencer
// assumes inclusion by bare name from the design files
`ifndef THBS_MAP_VH
`define THBS_MAP_VH
// ****************************************************************
// bus cycle kinds
// ****************************************************************
`define THBS_OP_DATA   3'h0
`define THBS_OP_IRQ_RD 3'h1
`define THBS_OP_IRQ_WR 3'h2
`define THBS_OP_BD_WR  3'h3
`define THBS_OP_BD_RD  3'h4
`define THBS_OP_PTR_RD 3'h5
// ****************************************************************
// hdlc constants
// ****************************************************************
`define THBS_FLAG      8'h7e
`define THBS_CRC_INIT  16'hffff
`define THBS_CRC_POLY  16'h8408
`define THBS_CRC_XOR   16'hffff
`define THBS_BYTES_PW  3'h4
`define THBS_BD_LAST   0
`define THBS_BD_DONE   32'h0000_8000
// ****************************************************************
// descriptor layout, byte offsets from the descriptor base
// ****************************************************************
`define THBS_BD_PTR_OFS 8'h04
`define THBS_BD_IRQ_OFS 8'h08
`define THBS_BD_SIZE    8'h0c
`endif

//--- verilog/thbs_word_store.v
// one-word staging memory for fetched long words, registered read
// assumes a single clock and a synchronous active-high reset
module thbs_word_store #(
  parameter WIDTH = 32                  // word width
) (
  input  wire             clk_in,       // system clock
  input  wire             sys_rst_in,   // sync reset
  input  wire             wr_in,        // write strobe
  input  wire [WIDTH-1:0] wdata_in,     // word to store
  output reg  [WIDTH-1:0] rdata_out     // stored word, registered
);
  // ****************************************************************
  // storage
  // ****************************************************************
  // single entry: the sequencer never fetches ahead, so no more needed
  always @(posedge clk_in) begin
    if (sys_rst_in) begin
      rdata_out <= {WIDTH{1'b0}};
    end else if (wr_in) begin
      rdata_out <= wdata_in;
    end
  end
endmodule

//--- verilog/thbs_tx_seq.v
// per-channel transmit sequencer: words in from memory, bytes out per
// tdm frame, crc and flags, buffer close and open
// assumes frame_tick_in marks each 125 us frame, the bus acks each cycle
`include "thbs_map.vh"
module thbs_tx_seq #(
  parameter AW = 32                       // bus address width
) (
  input  wire          clk_in,            // system clock, 250 mhz
  input  wire          sys_rst_in,        // sync reset, active high
  input  wire          enable_in,         // channel active
  input  wire [AW-1:0] bd_base_in,        // first descriptor address
  input  wire          frame_tick_in,     // one pulse per tdm frame
  input  wire          bus_ack_in,        // bus cycle done
  input  wire [31:0]   bus_rdata_in,      // read data
  output reg           bus_request_out,   // bus request level
  output reg           bus_we_out,        // write cycle
  output reg  [AW-1:0] bus_addr_out,      // cycle address
  output reg  [31:0]   bus_wdata_out,     // write data
  output reg  [2:0]    bus_op_out,        // cycle kind
  output reg  [7:0]    slot_byte_out,     // byte for this frame's slot
  output reg           slot_valid_out,    // pulse with slot_byte_out
  output reg           frame_end_out      // pulse when a buffer closes
);
  // ****************************************************************
  // states
  // ****************************************************************
  localparam S_IDLE  = 3'h0;
  localparam S_OPEN  = 3'h1;
  localparam S_FETCH = 3'h2;
  localparam S_DATA  = 3'h3;
  localparam S_CRC   = 3'h4;
  localparam S_CLOSE = 3'h5;
  localparam S_FLAG2 = 3'h6;

  // offsets sized to the address width so sums keep their width
  localparam [AW-1:0] PTR_OFS  = `THBS_BD_PTR_OFS;
  localparam [AW-1:0] IRQ_OFS  = `THBS_BD_IRQ_OFS;
  localparam [AW-1:0] BD_STEP  = `THBS_BD_SIZE;
  localparam [AW-1:0] WORD_OFS = `THBS_BYTES_PW;

  reg  [2:0]    state_q;
  reg  [2:0]    step_q;        // bus access index inside a frame
  reg  [1:0]    bidx_q;        // byte index within the word
  reg  [15:0]   len_q;         // bytes left in buffer
  reg  [15:0]   crc_q;
  reg           crc_hi_q;      // second crc byte pending
  reg  [AW-1:0] bd_q;          // descriptor address
  reg  [AW-1:0] ptr_q;         // data pointer
  wire          ws_wr;         // store strobe, with the data ack
  wire [31:0]   word_w;

  thbs_word_store #(.WIDTH(32)) u_store (
    .clk_in     (clk_in),
    .sys_rst_in (sys_rst_in),
    .wr_in      (ws_wr),
    .wdata_in   (bus_rdata_in),
    .rdata_out  (word_w)
  );

  // ****************************************************************
  // helpers
  // ****************************************************************
  // reflected crc-16 ccitt, one byte per call
  function [15:0] crc_byte;
    input [15:0] c;
    input [7:0]  d;
    integer      i;
    reg   [15:0] t;
    begin
      t = c;
      for (i = 0; i < 8; i = i + 1) begin
        if (t[0] ^ d[i]) begin
          t = (t >> 1) ^ `THBS_CRC_POLY;
        end else begin
          t = t >> 1;
        end
      end
      crc_byte = t;
    end
  endfunction

  // byte of a long word, first byte in the top lane
  function [7:0] pick;
    input [31:0] w;
    input [1:0]  k;
    begin
      case (k)
        2'h0:    pick = w[31:24];
        2'h1:    pick = w[23:16];
        2'h2:    pick = w[15:8];
        default: pick = w[7:0];
      endcase
    end
  endfunction

  wire [7:0]  cur_byte = pick(word_w, bidx_q);
  wire [15:0] crc_fin  = crc_q ^ `THBS_CRC_XOR;
  wire        bus_done = bus_request_out & bus_ack_in;

  // read data is only valid in the ack cycle, so the store must
  // capture it then; a registered strobe would catch stale data
  assign ws_wr = bus_done &&
                 ((state_q == S_FETCH) ||
                  (state_q == S_OPEN && step_q == 3'h2));

  // ****************************************************************
  // sequencer
  // ****************************************************************
  // bus cycles run only in fetch, close and open frames; byte frames
  // issue none, which keeps the steady load at one word per 4 frames
  always @(posedge clk_in) begin
    slot_valid_out <= 1'b0;
    frame_end_out  <= 1'b0;
    if (sys_rst_in) begin
      state_q         <= S_IDLE;
      step_q          <= 3'h0;
      bidx_q          <= 2'h0;
      len_q           <= 16'h0000;
      crc_q           <= `THBS_CRC_INIT;
      crc_hi_q        <= 1'b0;
      bd_q            <= {AW{1'b0}};
      ptr_q           <= {AW{1'b0}};
      bus_request_out <= 1'b0;
      bus_we_out      <= 1'b0;
      bus_addr_out    <= {AW{1'b0}};
      bus_wdata_out   <= 32'h0000_0000;
      bus_op_out      <= `THBS_OP_DATA;
      slot_byte_out   <= 8'h00;
    end else begin
      case (state_q)
        S_IDLE: begin
          if (enable_in && frame_tick_in) begin
            bd_q    <= bd_base_in;
            step_q  <= 3'h0;
            state_q <= S_OPEN;
          end
        end
        // open: status/len, data pointer, first word
        S_OPEN: begin
          if (step_q == 3'h0 && !bus_request_out) begin
            bus_request_out <= 1'b1;
            bus_we_out      <= 1'b0;
            bus_addr_out    <= bd_q;
            bus_op_out      <= `THBS_OP_BD_RD;
          end else if (bus_done) begin
            case (step_q)
              3'h0: begin
                len_q        <= bus_rdata_in[15:0];
                bus_addr_out <= bd_q + PTR_OFS;
                bus_op_out   <= `THBS_OP_PTR_RD;
                step_q       <= 3'h1;
              end
              3'h1: begin
                ptr_q        <= bus_rdata_in[AW-1:0];
                bus_addr_out <= bus_rdata_in[AW-1:0];
                bus_op_out   <= `THBS_OP_DATA;
                step_q       <= 3'h2;
              end
              default: begin
                bus_request_out <= 1'b0;
                ptr_q           <= ptr_q + WORD_OFS;
                bidx_q          <= 2'h0;
                crc_q           <= `THBS_CRC_INIT;
                step_q          <= 3'h0;
                state_q         <= S_DATA;
              end
            endcase
          end
        end
        // one bus cycle fetches a whole long word
        S_FETCH: begin
          if (!bus_request_out) begin
            bus_request_out <= 1'b1;
            bus_we_out      <= 1'b0;
            bus_addr_out    <= ptr_q;
            bus_op_out      <= `THBS_OP_DATA;
          end else if (bus_done) begin
            bus_request_out <= 1'b0;
            ptr_q           <= ptr_q + WORD_OFS;
            bidx_q          <= 2'h0;
            state_q         <= S_DATA;
          end
        end
        // one byte per frame, no bus cycles
        S_DATA: begin
          if (frame_tick_in) begin
            slot_byte_out  <= cur_byte;
            slot_valid_out <= 1'b1;
            crc_q          <= crc_byte(crc_q, cur_byte);
            len_q          <= len_q - 16'h0001;
            bidx_q         <= bidx_q + 2'h1;
            if (len_q <= 16'h0001) begin
              crc_hi_q <= 1'b0;
              state_q  <= S_CRC;
            end else if (bidx_q == 2'h3) begin
              state_q <= S_FETCH;   // fetch runs early in this same frame
            end
          end
        end
        // crc low byte then high byte, two frames
        S_CRC: begin
          if (frame_tick_in) begin
            slot_valid_out <= 1'b1;
            if (!crc_hi_q) begin
              slot_byte_out <= crc_fin[7:0];
              crc_hi_q      <= 1'b1;
            end else begin
              slot_byte_out <= crc_fin[15:8];
              step_q        <= 3'h0;
              state_q       <= S_CLOSE;
            end
          end
        end
        // flag, then irq read, irq write, bd status write
        S_CLOSE: begin
          if (frame_tick_in && step_q == 3'h0 && !bus_request_out) begin
            slot_byte_out   <= `THBS_FLAG;
            slot_valid_out  <= 1'b1;
            bus_request_out <= 1'b1;
            bus_we_out      <= 1'b0;
            bus_addr_out    <= bd_q + IRQ_OFS;
            bus_op_out      <= `THBS_OP_IRQ_RD;
          end else if (bus_done) begin
            case (step_q)
              3'h0: begin
                bus_we_out    <= 1'b1;
                bus_wdata_out <= bus_rdata_in | `THBS_BD_DONE;
                bus_op_out    <= `THBS_OP_IRQ_WR;
                step_q        <= 3'h1;
              end
              3'h1: begin
                bus_addr_out  <= bd_q;
                bus_wdata_out <= `THBS_BD_DONE;
                bus_op_out    <= `THBS_OP_BD_WR;
                step_q        <= 3'h2;
              end
              default: begin
                bus_request_out <= 1'b0;
                bus_we_out      <= 1'b0;
                frame_end_out   <= 1'b1;
                bd_q            <= bd_q + BD_STEP;
                step_q          <= 3'h0;
                state_q         <= S_FLAG2;
              end
            endcase
          end
        end
        // second flag, then open the next buffer in this frame if enable_in is high, else go idle
        S_FLAG2: begin
          if (frame_tick_in) begin
            slot_byte_out  <= `THBS_FLAG;
            slot_valid_out <= 1'b1;
            step_q         <= 3'h0;
            state_q        <= enable_in ? S_OPEN : S_IDLE;
          end
        end
        default: state_q <= S_IDLE;
      endcase
    end
  end
endmodule

//--- dv/thbs_tx_seq_asserts.sv
// checker for the transmit buffer switch sequencer, bound to its ports
// assumes one clock and the synchronous active-high reset
`include "thbs_map.vh"
module thbs_tx_seq_asserts #(
  parameter AW = 32
) (
  input wire logic          clk_in,          // system clock
  input wire logic          sys_rst_in,      // sync reset
  input wire logic          frame_tick_in,   // frame pulse
  input wire logic          bus_ack_in,      // cycle done
  input wire logic [31:0]   bus_rdata_in,    // read data
  input wire logic          bus_request_out, // cycle pending
  input wire logic          bus_we_out,      // write cycle
  input wire logic [AW-1:0] bus_addr_out,    // address
  input wire logic [31:0]   bus_wdata_out,   // write data
  input wire logic [2:0]    bus_op_out,      // cycle kind
  input wire logic          slot_valid_out,  // byte strobe
  input wire logic          frame_end_out    // buffer closed
);
  // ****************************************************************
  // bus and slot relations
  // ****************************************************************
  default clocking @(posedge clk_in); endclocking
  default disable iff (sys_rst_in);
  wire cyc_done = bus_request_out && bus_ack_in;
  wire [2:0] op = bus_op_out;
  property p_hold_cycle;
    bus_request_out && !bus_ack_in |=> bus_request_out
      && $stable(bus_addr_out) && $stable(bus_op_out);
  endproperty
  a_hold_cycle: assert property (p_hold_cycle)
    else $error("bus cycle changed before ack");
  property p_data_read;
    bus_request_out && op == `THBS_OP_DATA |-> !bus_we_out;
  endproperty
  a_data_read: assert property (p_data_read)
    else $error("data fetch is not a read");
  property p_slot_tick;
    slot_valid_out |-> $past(frame_tick_in);
  endproperty
  a_slot_tick: assert property (p_slot_tick)
    else $error("slot byte not one clock after tick");
  property p_slot_pulse;
    slot_valid_out |=> !slot_valid_out;
  endproperty
  a_slot_pulse: assert property (p_slot_pulse)
    else $error("slot strobe longer than one clock");
  property p_ptr_after_bd;
    cyc_done && op == `THBS_OP_BD_RD |=> bus_request_out
      && op == `THBS_OP_PTR_RD && bus_addr_out == $past(bus_addr_out) + 'h4;
  endproperty
  a_ptr_after_bd: assert property (p_ptr_after_bd)
    else $error("pointer read does not follow status read");
  property p_data_after_ptr;
    cyc_done && op == `THBS_OP_PTR_RD |=> op == `THBS_OP_DATA
      && bus_addr_out == $past(bus_rdata_in);
  endproperty
  a_data_after_ptr: assert property (p_data_after_ptr)
    else $error("first data read not at fetched pointer");
  property p_irq_write;
    cyc_done && op == `THBS_OP_IRQ_RD |=> bus_we_out && op == `THBS_OP_IRQ_WR
      && bus_wdata_out == ($past(bus_rdata_in) | `THBS_BD_DONE);
  endproperty
  a_irq_write: assert property (p_irq_write)
    else $error("interrupt table write wrong");
  property p_bd_write;
    cyc_done && op == `THBS_OP_IRQ_WR |=> bus_we_out && op == `THBS_OP_BD_WR
      && bus_wdata_out == `THBS_BD_DONE;
  endproperty
  a_bd_write: assert property (p_bd_write)
    else $error("descriptor status write wrong");
  property p_close_end;
    cyc_done && op == `THBS_OP_BD_WR |=> frame_end_out && !bus_request_out;
  endproperty
  a_close_end: assert property (p_close_end)
    else $error("close did not end with frame end pulse");
endmodule
bind thbs_tx_seq thbs_tx_seq_asserts #(.AW(AW)) i_thbs_tx_seq_asserts (
  .clk_in(clk_in), .sys_rst_in(sys_rst_in), .frame_tick_in(frame_tick_in),
  .bus_ack_in(bus_ack_in), .bus_rdata_in(bus_rdata_in),
  .bus_request_out(bus_request_out), .bus_we_out(bus_we_out),
  .bus_addr_out(bus_addr_out), .bus_wdata_out(bus_wdata_out),
  .bus_op_out(bus_op_out), .slot_valid_out(slot_valid_out),
  .frame_end_out(frame_end_out));

//--- dv/thbs_mem_model.sv
// bus and buffer memory for one requester, answers after a random wait
// assumes requests held until ack; bench preloads mem hierarchically
module thbs_mem_model (
  input  wire logic        clk_in,   // system clock
  input  wire logic        req_in,   // cycle pending
  input  wire logic        we_in,    // write cycle
  input  wire logic [31:0] addr_in,  // cycle address
  input  wire logic [31:0] wdata_in, // write data
  output logic             ack_out,  // cycle done pulse
  output logic [31:0]      rdata_out // read data with ack
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] mem [0:255];
  int unsigned wait_q;
  initial begin
    ack_out = 1'b0;
    rdata_out = 32'h0;
    wait_q = 0;
  end
  // grant latency 1 to 7 clocks, under the tolerated averages;
  // read data toggles outside ack so a stale value never looks valid
  always @(posedge clk_in) begin
    if (ack_out || !req_in) begin
      ack_out <= 1'b0;
      rdata_out <= ~rdata_out;
      wait_q <= $urandom_range(6, 0);
    end else if (wait_q == 0) begin
      ack_out <= 1'b1;
      rdata_out <= mem[addr_in[9:2]];
      if (we_in) mem[addr_in[9:2]] <= wdata_in;
    end else begin
      wait_q <= wait_q - 1;
      rdata_out <= ~rdata_out;
    end
  end
endmodule

//--- dv/tdm_hdlc_tx_buffer_switch_test.sv
// testbench: one channel through two buffer switches, per-frame checks
// assumes frames shortened to 48 clocks; bus work fits well inside
module tdm_hdlc_tx_buffer_switch_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_in, sys_rst_in, enable_in, frame_tick_in;
  logic [31:0] bd_base_in;
  wire bus_ack_in, bus_request_out, bus_we_out, slot_valid_out, frame_end_out;
  wire [31:0] bus_rdata_in, bus_addr_out, bus_wdata_out;
  wire [2:0] bus_op_out;
  wire [7:0] slot_byte_out;
  int mismatches, samples_checked, snap_n, cnt_n, nfr;
  logic [7:0] snap_b, cnt_b;
  logic snap_v, cnt_v;
  logic [67:0] exp_bus[$];
  logic [12:0] exp_fr[$];
  logic [67:0] got_bus;
  logic [12:0] got_fr, exp_f;
  thbs_tx_seq #(.AW(32)) i_thbs_tx_seq (.clk_in(clk_in),
    .sys_rst_in(sys_rst_in), .enable_in(enable_in), .bd_base_in(bd_base_in),
    .frame_tick_in(frame_tick_in), .bus_ack_in(bus_ack_in),
    .bus_rdata_in(bus_rdata_in), .bus_request_out(bus_request_out),
    .bus_we_out(bus_we_out), .bus_addr_out(bus_addr_out),
    .bus_wdata_out(bus_wdata_out), .bus_op_out(bus_op_out),
    .slot_byte_out(slot_byte_out), .slot_valid_out(slot_valid_out),
    .frame_end_out(frame_end_out));
  thbs_mem_model i_thbs_mem_model (.clk_in(clk_in), .req_in(bus_request_out),
    .we_in(bus_we_out), .addr_in(bus_addr_out), .wdata_in(bus_wdata_out),
    .ack_out(bus_ack_in), .rdata_out(bus_rdata_in));
  // ****************************************************************
  // expectations
  // ****************************************************************
  function automatic logic [15:0] crc_step(logic [15:0] c, logic [7:0] d);
    for (int i = 0; i < 8; i++) begin
      c = (c[0] ^ d[i]) ? (c >> 1) ^ 16'h8408 : c >> 1;
    end
    return c;
  endfunction
  task automatic chk(input logic [67:0] got, input logic [67:0] exp);
    samples_checked++;
    if (got !== exp) begin
      mismatches++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // fills memory for buffer k and queues its bus cycles and frames; for k == 2 only its three open cycles
  task automatic add_buf(input int k, input int len);
    logic [31:0] bd, ptr, irq;
    logic [31:0] wd[4];
    logic [15:0] crc;
    logic [7:0] b;
    logic f;
    bd = bd_base_in + 12 * k;
    ptr = 32'h200 + 32'h40 * k;
    irq = $urandom();
    crc = 16'hffff;
    i_thbs_mem_model.mem[bd[9:2]] = {16'h0, len[15:0]};
    i_thbs_mem_model.mem[bd[9:2] + 1] = ptr;
    i_thbs_mem_model.mem[bd[9:2] + 2] = irq;
    for (int j = 0; j < 4; j++) begin
      wd[j] = $urandom();
      i_thbs_mem_model.mem[ptr[9:2] + j] = wd[j];
    end
    exp_bus.push_back({4'h4, bd, 32'h0});
    exp_bus.push_back({4'h5, bd + 32'h4, 32'h0});
    exp_bus.push_back({4'h0, ptr, 32'h0});
    if (k == 2) return;
    for (int i = 0; i < len; i++) begin
      b = wd[i / 4] >> (24 - 8 * (i % 4));
      crc = crc_step(crc, b);
      f = (i % 4 == 3) && (i + 1 < len);
      exp_fr.push_back({1'b1, b, 3'h0, f});
      if (f) exp_bus.push_back({4'h0, ptr + i + 1, 32'h0});
    end
    crc = ~crc;
    exp_fr.push_back({1'b1, crc[7:0], 4'h0});
    exp_fr.push_back({1'b1, crc[15:8], 4'h0});
    exp_fr.push_back({1'b1, 8'h7e, 4'h3});
    exp_fr.push_back({1'b1, 8'h7e, 4'h3});
    exp_bus.push_back({4'h1, bd + 32'h8, 32'h0});
    exp_bus.push_back({4'ha, bd + 32'h8, irq | 32'h8000});
    exp_bus.push_back({4'hb, bd, 32'h8000});
  endtask
  task automatic finish_test;
    $display("comparisons %0d, mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ****************************************************************
  // clock, monitor, watchdog and sequence
  // ****************************************************************
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // per-frame tallies snapshot at each tick; every bus cycle compared
  always @(posedge clk_in) begin
    if (frame_tick_in === 1'b1) begin
      snap_n = cnt_n;
      snap_b = cnt_b;
      snap_v = cnt_v;
      cnt_n = 0;
      cnt_v = 1'b0;
      cnt_b = 8'h0;
    end
    if (bus_request_out === 1'b1 && bus_ack_in === 1'b1) begin
      cnt_n++;
      got_bus = {bus_we_out, bus_op_out, bus_addr_out,
        bus_we_out ? bus_wdata_out : 32'h0};
      chk(got_bus, exp_bus.pop_front());
    end
    if (slot_valid_out === 1'b1) begin
      cnt_v = 1'b1;
      cnt_b = slot_byte_out;
    end
  end
  // bound: 2000 clocks, just over 41 frames of 48 clocks
  initial begin
    repeat (2000) @(posedge clk_in);
    mismatches++;
    finish_test();
  end
  initial begin
    void'($urandom(32'hafcd3c2f));
    // reset asserted and channel idle before the first clock edge
    sys_rst_in <= 1'b1;
    enable_in <= 1'b0;
    frame_tick_in <= 1'b0;
    cnt_n = 0;
    cnt_v = 1'b0;
    cnt_b = 8'h00;
    mismatches = 0;
    samples_checked = 0;
    bd_base_in = 32'($urandom_range(0, 7)) * 32'h40;
    add_buf(0, 5); // partial last word
    add_buf(1, $urandom_range(1, 16));
    add_buf(2, 4);
    nfr = exp_fr.size();
    repeat (2) @(posedge clk_in);
    sys_rst_in <= 1'b0;
    #1 chk({bus_request_out, slot_valid_out, frame_end_out}, 3'h0);
    // one channel only, so buffer starts are spread by construction
    for (int f = 0; f <= nfr + 2; f++) begin
      @(posedge clk_in);
      enable_in <= (f > 0);
      frame_tick_in <= 1'b1;
      @(posedge clk_in);
      frame_tick_in <= 1'b0;
      #1;
      got_fr = {snap_v, snap_b, snap_n[3:0]};
      if (f == 1) chk(got_fr, 13'h0);
      if (f == 2) chk(snap_n[3:0], 4'h3);
      if (f > 2) begin
        exp_f = exp_fr.pop_front();
        chk(got_fr[12:4], exp_f[12:4]);
        chk(got_fr[3:0], exp_f[3:0]);
      end
      repeat (46) @(posedge clk_in);
    end
    chk(exp_bus.size(), 0);
    $display("buffer switch test done");
    finish_test();
  end
endmodule
